//--- design/dcfg_top.sv
/*
 * Data configuration logic of the DMA unit: the write-only configuration
 * register, address and byte-lane shaping, FIFO threshold bus request,
 * burst length and send packet gating.
 * Assumes one 100 MHz clock, synchronous inputs, a FIFO level in bytes
 * and a host that never asserts both register strobes at once.
 */
// Chosen here: the address-and-strobe port.
// Operation
// - Bit 0 selects byte transfers when clear and word transfers when set, for remote and local DMA alike.
// - In word mode the address reaches 32k words and address bit zero is held low.
// - With byte order clear the MS byte goes on the upper lanes, with it set the lanes swap.
// - Byte order is ignored in byte mode.
// - Long address clear gives dual 16-bit addressing, set puts the remote start address on the upper sixteen lines.
// - Long address select is set at reset.
// - Loopback select clear means loopback mode, set means normal operation.
// - With auto-remote set the send packet command runs, with it clear it is refused.
// - In reception the bus is requested once the FIFO holds 2, 4, 8 or 12 bytes by code.
// - The burst length follows the threshold code.
// - In transmission the bus is requested at thirteen bytes less the receive threshold.
`timescale 1ns/1ps
`include "dcfg_defs.svh"

module dcfg_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire dcfg_pkg::dcfg_reg_t i_reg_addr,
	input wire dcfg_pkg::dcfg_reg_t i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	output dcfg_pkg::dcfg_reg_t o_reg_rdata,
	input wire dcfg_pkg::dcfg_word_t i_chan_addr,
	input wire dcfg_pkg::dcfg_word_t i_remote_start_addr,
	output dcfg_pkg::dcfg_addr_t o_dma_addr,
	input wire dcfg_pkg::dcfg_word_t i_wr_data,
	output dcfg_pkg::dcfg_word_t o_bus_data,
	input wire dcfg_pkg::dcfg_word_t i_bus_data,
	output dcfg_pkg::dcfg_word_t o_rd_data,
	input wire logic i_rx_active,
	input wire logic i_tx_active,
	input wire dcfg_pkg::dcfg_level_t i_fifo_level,
	output logic o_bus_request_out,
	output dcfg_pkg::dcfg_level_t o_burst_len,
	input wire logic i_send_cmd,
	output logic o_send_exec,
	output logic o_send_refused,
	output logic o_word_mode,
	output logic o_loopback_mode
);
	import dcfg_pkg::*;

	dcfg_reg_t data_config_q;
	dcfg_dir_e dir;
	dcfg_level_t rx_thr;
	dcfg_level_t tx_thr;
	dcfg_level_t burst_d;
	logic word_sel;
	logic swap_sel;
	logic bus_request_d;

	function automatic dcfg_level_t thr_bytes(input logic [1:0] code);
		case (code)
			2'h0: thr_bytes = `DCFG_THR_CODE0_BYTES;
			2'h1: thr_bytes = `DCFG_THR_CODE1_BYTES;
			2'h2: thr_bytes = `DCFG_THR_CODE2_BYTES;
			default: thr_bytes = `DCFG_THR_CODE3_BYTES;
		endcase
	endfunction

	function automatic dcfg_word_t lanes(input dcfg_word_t d,
		input logic word, input logic swap);
		if (!word) begin
			lanes = {8'h00, d[7:0]};
		end else if (swap) begin
			lanes = {d[7:0], d[15:8]};
		end else begin
			lanes = d;
		end
	endfunction

	assign word_sel = data_config_q[`DCFG_BIT_WORD];
	assign swap_sel = word_sel & data_config_q[`DCFG_BIT_BYTE_ORDER];
	assign rx_thr = thr_bytes(
		data_config_q[`DCFG_BIT_FT_HI:`DCFG_BIT_FT_LO]);
	assign tx_thr = `DCFG_TX_TOTAL_BYTES - rx_thr;

	always_comb begin
		if (i_rx_active) begin
			dir = DCFG_DIR_RX;
		end else if (i_tx_active) begin
			dir = DCFG_DIR_TX;
		end else begin
			dir = DCFG_DIR_IDLE;
		end
	end

	always_comb begin
		case (dir)
			DCFG_DIR_RX: bus_request_d = (i_fifo_level >= rx_thr);
			DCFG_DIR_TX: bus_request_d = (i_fifo_level >= tx_thr);
			default: bus_request_d = 1'b0;
		endcase
	end

	always_comb begin
		if (word_sel) begin
			burst_d = {1'b0, rx_thr[4:1]};
		end else begin
			burst_d = rx_thr;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			data_config_q <= `DCFG_DATA_CONFIG_RST;
		end else if (i_reg_we && i_reg_addr == `DCFG_ADDR_DATA_CONFIG) begin
			data_config_q <= i_reg_wdata & `DCFG_DATA_CONFIG_MASK;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_re && i_reg_addr == `DCFG_ADDR_STATUS) begin
			o_reg_rdata <= {o_bus_request_out, o_loopback_mode,
				data_config_q[5:0]};
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_dma_addr <= 32'h0000_0000;
		end else begin
			o_dma_addr[15:1] <= i_chan_addr[15:1];
			o_dma_addr[0] <= i_chan_addr[0] & ~word_sel;
			if (data_config_q[`DCFG_BIT_LONG_ADDR]) begin
				o_dma_addr[31:16] <= i_remote_start_addr;
			end else begin
				o_dma_addr[31:16] <= 16'h0000;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bus_data <= 16'h0000;
			o_rd_data <= 16'h0000;
		end else begin
			o_bus_data <= lanes(i_wr_data, word_sel, swap_sel);
			o_rd_data <= lanes(i_bus_data, word_sel, swap_sel);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bus_request_out <= 1'b0;
			o_burst_len <= 5'h00;
		end else begin
			o_bus_request_out <= bus_request_d;
			o_burst_len <= burst_d;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_send_exec <= 1'b0;
			o_send_refused <= 1'b0;
		end else begin
			o_send_exec <= i_send_cmd &
				data_config_q[`DCFG_BIT_AUTO_REMOTE];
			o_send_refused <= i_send_cmd &
				~data_config_q[`DCFG_BIT_AUTO_REMOTE];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_word_mode <= 1'b0;
			o_loopback_mode <= 1'b0;
		end else begin
			o_word_mode <= word_sel;
			o_loopback_mode <= ~data_config_q[`DCFG_BIT_LOOPBACK];
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_word_mode_follows: assert property (
		i_reg_we && i_reg_addr == 8'h0E ##1 1'b1 |=> o_word_mode ==
		$past(i_reg_wdata[0], 2)
	) else $error("Word mode does not follow the written bit.");

	a_word_mode_level: assert property (
		!$past(i_rst) |-> o_word_mode == $past(data_config_q[0])
	) else $error("Word mode output differs from the register.");

	a_addr_bit_zero: assert property (
		!$past(i_rst) && $past(word_sel) |-> o_dma_addr[0] == 1'b0
	) else $error("Address bit zero driven in word mode.");

	a_lane_order: assert property (
		!$past(i_rst) && $past(word_sel) && !$past(swap_sel) |->
		o_bus_data == $past(i_wr_data)
	) else $error("Lanes not in natural order.");

	a_lane_swap: assert property (
		!$past(i_rst) && $past(swap_sel) |->
		o_bus_data == {$past(i_wr_data[7:0]), $past(i_wr_data[15:8])}
	) else $error("Lanes not swapped.");

	a_byte_ignores_order: assert property (
		!$past(i_rst) && !$past(word_sel) |->
		o_bus_data[15:8] == 8'h00 &&
		o_bus_data[7:0] == $past(i_wr_data[7:0])
	) else $error("Byte mode affected by byte order.");

	a_long_addr_upper: assert property (
		!$past(i_rst) && $past(data_config_q[2]) |->
		o_dma_addr[31:16] == $past(i_remote_start_addr)
	) else $error("Upper address lines wrong in long mode.");

	a_dual_addr_zero: assert property (
		!$past(i_rst) && !$past(data_config_q[2]) |->
		o_dma_addr[31:16] == 16'h0000
	) else $error("Upper address lines driven in dual mode.");

	a_reset_long_addr: assert property (
		$past(i_rst) && !i_rst |->
		data_config_q == `DCFG_DATA_CONFIG_RST
	) else $error("Configuration wrong after reset.");

	a_loopback_level: assert property (
		!$past(i_rst) && $past(data_config_q[3]) |-> !o_loopback_mode
	) else $error("Loopback asserted in normal operation.");

	a_loopback_set: assert property (
		!$past(i_rst) && !$past(data_config_q[3]) |-> o_loopback_mode
	) else $error("Loopback missing with the select bit clear.");

	a_send_quiet: assert property (
		!i_send_cmd |=> !o_send_exec && !o_send_refused
	) else $error("Send outcome without a command.");

	a_send_gating: assert property (
		i_send_cmd |=> o_send_exec != o_send_refused
	) else $error("Send command neither run nor refused.");

	a_rx_threshold: assert property (
		i_rx_active && i_fifo_level < 5'h02 |=> !o_bus_request_out
	) else $error("Bus requested below the least threshold.");

	a_rx_high_level: assert property (
		i_rx_active && i_fifo_level >= 5'h0C |=> o_bus_request_out
	) else $error("Receive request missed above any threshold.");

	a_idle_no_request: assert property (
		!i_rx_active && !i_tx_active |=> !o_bus_request_out
	) else $error("Bus requested while idle.");

	a_tx_empty_quiet: assert property (
		!i_rx_active && i_tx_active && i_fifo_level == 5'h00 |=>
		!o_bus_request_out
	) else $error("Transmit request with an empty FIFO.");

	a_tx_threshold: assert property (
		!i_rx_active && i_tx_active && i_fifo_level >= 5'h0B |=>
		o_bus_request_out
	) else $error("Transmit request missed above any threshold.");

	a_burst_nonzero: assert property (
		!$past(i_rst) |-> o_burst_len >= 5'h01 && o_burst_len <= 5'h0C
	) else $error("Burst length out of range.");

	a_burst_word: assert property (
		!$past(i_rst) && $past(word_sel) |-> o_burst_len <= 5'h06
	) else $error("Word burst length out of range.");

	c_word_swap: cover property (word_sel && swap_sel);
	c_rx_request: cover property (i_rx_active ##1 o_bus_request_out);
	c_tx_request: cover property (i_tx_active && !i_rx_active
		##1 o_bus_request_out);
	c_send_run: cover property (o_send_exec);
	c_loopback: cover property (o_loopback_mode ##1 !o_loopback_mode);
endmodule

//--- include/dcfg_defs.svh
/*
 * Offsets, field positions, reset values and counts of the data
 * configuration block.
 * Assumes an 8-bit register port and a FIFO level counted in bytes.
 */
`ifndef DCFG_DEFS_SVH
`define DCFG_DEFS_SVH

`define DCFG_ADDR_DATA_CONFIG 8'h0E
`define DCFG_ADDR_STATUS 8'h10
`define DCFG_DATA_CONFIG_RST 8'h04
`define DCFG_DATA_CONFIG_MASK 8'h7F
`define DCFG_BIT_WORD 0
`define DCFG_BIT_BYTE_ORDER 1
`define DCFG_BIT_LONG_ADDR 2
`define DCFG_BIT_LOOPBACK 3
`define DCFG_BIT_AUTO_REMOTE 4
`define DCFG_BIT_FT_LO 5
`define DCFG_BIT_FT_HI 6
`define DCFG_TX_TOTAL_BYTES 5'h0D
`define DCFG_THR_CODE0_BYTES 5'h02
`define DCFG_THR_CODE1_BYTES 5'h04
`define DCFG_THR_CODE2_BYTES 5'h08
`define DCFG_THR_CODE3_BYTES 5'h0C

`endif

//--- include/dcfg_pkg.sv
/*
 * Types shared by the data configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dcfg_pkg;
	typedef logic [7:0] dcfg_reg_t;
	typedef logic [15:0] dcfg_word_t;
	typedef logic [31:0] dcfg_addr_t;
	typedef logic [4:0] dcfg_level_t;
	typedef enum logic [1:0] {
		DCFG_DIR_IDLE,
		DCFG_DIR_RX,
		DCFG_DIR_TX
	} dcfg_dir_e;
endpackage

//--- tb/dcfg_mem.sv
/*
 * Buffer memory model on the system bus.
 * Assumes the DMA address is settled by the clock edge that samples data.
 */
`timescale 1ns/1ps
module dcfg_mem (
	input wire logic i_clk,
	input wire dcfg_pkg::dcfg_addr_t i_addr,
	output dcfg_pkg::dcfg_word_t o_data
);
	import dcfg_pkg::*;
	// Each address returns a fixed scrambled word.
	assign o_data = i_addr[15:0] ^ 16'hA55A;
endmodule

//--- tb/dcfg_top_tb.sv
/*
 * Self-checking testbench of the data configuration block.
 * Assumes the design and the memory model are compiled before it.
 */
`timescale 1ns/1ps
module dcfg_top_tb;
	import dcfg_pkg::*;
	logic i_clk = 0, i_rst = 1, i_reg_we = 0, i_reg_re = 0;
	logic i_rx_active = 0, i_tx_active = 0, i_send_cmd = 0;
	dcfg_reg_t i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
	dcfg_word_t i_chan_addr = 16'h1235, i_remote_start_addr = 16'h8421;
	dcfg_word_t i_wr_data = 16'hABCD, i_bus_data, o_bus_data, o_rd_data;
	dcfg_addr_t o_dma_addr;
	dcfg_level_t i_fifo_level = 5'h00, o_burst_len;
	logic o_bus_request_out, o_send_exec, o_send_refused;
	logic o_word_mode, o_loopback_mode;
	int fail_count = 0, checks_done = 0;
	logic [4:0] thr[4] = '{5'h02, 5'h04, 5'h08, 5'h0C};
	always #5 i_clk = ~i_clk;
	dcfg_top u_dcfg_top (.i_clk(i_clk), .i_rst(i_rst),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_we(i_reg_we), .i_reg_re(i_reg_re), .o_reg_rdata(o_reg_rdata),
		.i_chan_addr(i_chan_addr), .i_remote_start_addr(i_remote_start_addr),
		.o_dma_addr(o_dma_addr), .i_wr_data(i_wr_data),
		.o_bus_data(o_bus_data), .i_bus_data(i_bus_data),
		.o_rd_data(o_rd_data), .i_rx_active(i_rx_active),
		.i_tx_active(i_tx_active), .i_fifo_level(i_fifo_level),
		.o_bus_request_out(o_bus_request_out), .o_burst_len(o_burst_len),
		.i_send_cmd(i_send_cmd), .o_send_exec(o_send_exec),
		.o_send_refused(o_send_refused), .o_word_mode(o_word_mode),
		.o_loopback_mode(o_loopback_mode));
	dcfg_mem u_dcfg_mem (.i_clk(i_clk), .i_addr(o_dma_addr),
		.o_data(i_bus_data));
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input dcfg_reg_t a, input dcfg_reg_t d);
		@(posedge i_clk);
		i_reg_we <= 1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_we <= 0;
	endtask
	task automatic rd_chk(input dcfg_reg_t a, input dcfg_reg_t e);
		@(posedge i_clk);
		i_reg_re <= 1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_re <= 0;
		#1;
		chk(o_reg_rdata, e, "register read");
	endtask
	task automatic cfg(input dcfg_reg_t v);
		wr(8'h0E, v);
		settle(4);
	endtask
	task automatic t_reset;
		settle(2);
		chk(o_loopback_mode, 1, "reset loopback");
		chk(o_dma_addr, {16'h8421, 16'h1235}, "reset long addr");
		rd_chk(8'h10, 8'h44);
		$display("test reset done");
	endtask
	task automatic t_lanes;
		cfg(8'h0B);
		chk(o_word_mode, 1, "word mode");
		chk(o_loopback_mode, 0, "normal op");
		chk(o_dma_addr, {16'h0000, 16'h1234}, "dual addr");
		chk(o_bus_data, 16'hCDAB, "swap out");
		chk(o_rd_data, 16'h6EB7, "swap in");
		cfg(8'h05);
		chk(o_loopback_mode, 1, "loopback");
		chk(o_dma_addr, {16'h8421, 16'h1234}, "long addr");
		chk(o_bus_data, 16'hABCD, "lanes out");
		chk(o_rd_data, 16'hB76E, "lanes in");
		cfg(8'h02);
		chk(o_word_mode, 0, "byte mode");
		chk(o_dma_addr, {16'h0000, 16'h1235}, "byte addr");
		chk(o_bus_data, 16'h00CD, "byte out");
		chk(o_rd_data, 16'h006F, "byte in");
		$display("test lanes done");
	endtask
	task automatic t_thr;
		for (int w = 0; w < 2; w++) begin
			for (int c = 0; c < 4; c++) begin
				cfg(8'h08 | dcfg_reg_t'(c << 5) | dcfg_reg_t'(w));
				chk(o_burst_len, w ? thr[c] >> 1 : thr[c], "burst");
				i_rx_active <= 1;
				i_fifo_level <= thr[c] - 5'h01;
				settle(2);
				chk(o_bus_request_out, 0, "rx early");
				i_fifo_level <= thr[c];
				settle(2);
				chk(o_bus_request_out, 1, "rx request");
				i_rx_active <= 0;
				i_tx_active <= 1;
				i_fifo_level <= 5'h0C - thr[c];
				settle(2);
				chk(o_bus_request_out, 0, "tx early");
				i_fifo_level <= 5'h0D - thr[c];
				settle(2);
				chk(o_bus_request_out, 1, "tx request");
				i_tx_active <= 0;
			end
		end
		$display("test thresholds done");
	endtask
	task automatic t_send;
		for (int a = 1; a >= 0; a--) begin
			cfg(a ? 8'h18 : 8'h08);
			@(posedge i_clk);
			i_send_cmd <= 1;
			@(posedge i_clk);
			i_send_cmd <= 0;
			#1;
			chk(o_send_exec, a, "send exec");
			chk(o_send_refused, !a, "send refused");
		end
		$display("test send done");
	endtask
	task automatic t_bus;
		wr(8'h0F, 8'h01);
		settle(4);
		chk(o_word_mode, 0, "stray write");
		rd_chk(8'h0E, 8'h00);
		cfg(8'hFF);
		rd_chk(8'h10, 8'h3F);
		$display("test bus done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 0;
		t_reset();
		t_lanes();
		t_thr();
		t_send();
		t_bus();
		final_report();
	end
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule
